// ==== bench/flash_host_ctrl_asserts.sv ====
// Checker: pin timing and handshake properties at the flash host controller ports.
`timescale 1ns/1ps
module flash_host_ctrl_chk
	import flash_host_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// User side
	input wire logic        reqValid,
	input wire logic        reqReady,
	input wire logic        rspValid,
	input wire logic        busyProgram,
	// Flash pins
	input wire logic        chipSelN,
	input wire logic        writeStrobeN,
	input wire logic        outEnableN,
	input wire logic [23:0] flashAddr,
	input wire logic [15:0] dqOut,
	input wire logic        dqOe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	a_strobe_excl: assert property (!(!writeStrobeN && !outEnableN))
		else $error("write and read strobes low together");
	a_write_select: assert property (!writeStrobeN |-> !chipSelN && dqOe)
		else $error("write strobe without select or driven data");
	a_write_hold: assert property ($fell(writeStrobeN) |=> !writeStrobeN && $stable(dqOut)
		&& $stable(flashAddr) ##1 writeStrobeN && $stable(dqOut))
		else $error("write pulse width or data hold wrong");
	a_read_width: assert property ($fell(outEnableN) |=> !outEnableN [*2] ##1 outEnableN)
		else $error("read strobe width wrong");
	a_read_release: assert property (!outEnableN |-> !dqOe)
		else $error("data driven during a read");
	a_cycle_span: assert property ($fell(chipSelN) |-> ##[4:5] $rose(chipSelN))
		else $error("bus cycle length wrong");
	a_busy_quiet: assert property (busyProgram |-> writeStrobeN)
		else $error("write while program runs");
	a_take_busy: assert property (reqValid && reqReady |=> !reqReady)
		else $error("ready stays high after a request");
	a_rsp_pulse: assert property (rspValid |=> !rspValid)
		else $error("answer pulse longer than one cycle");
	a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> chipSelN && writeStrobeN
		&& outEnableN && !dqOe)
		else $error("pins active after reset");
endmodule : flash_host_ctrl_chk

bind flash_host_ctrl flash_host_ctrl_chk chk (.clk_sys, .nrst, .reqValid, .reqReady, .rspValid,
	.busyProgram, .chipSelN, .writeStrobeN, .outEnableN, .flashAddr, .dqOut, .dqOe);

// ==== bench/flash_host_ctrl_test.sv ====
// Testbench: user-side sequences through the flash host controller into a device model.
`timescale 1ns/1ps
module flash_host_ctrl_test
	import flash_host_pkg::*;
;
	localparam logic [0:4][15:0]  ID_V = {16'h00C3, 16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h0011};
	localparam logic [0:4][7:0]   ID_A = {8'h00, 8'h01, 8'h0E, 8'h0F, 8'h03};
	localparam logic [0:16][15:0] QTAB = {16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033,
		16'h0009, 16'h0002, 16'h0001, 16'h0000, 16'h0004, 16'h0000, 16'h0000, 16'h0001,
		16'h00B5, 16'h00C5, 16'h0002, 16'h0001};
	logic        clk_sys, nrst, clkEn, reqValid, reqReady, rspValid, rspError;
	logic        busyProgram, regionActive, queryMismatch, badLayout, failProg;
	logic        chipSelN, writeStrobeN, outEnableN, dqOe;
	logic [23:0] flashAddr;
	logic [15:0] rspData, dqOut, dqIn;
	req_t        req;
	int          failures, compares, cycles;
	////////////////////////////////////////
	flash_host_ctrl #(.POLL_LIMIT(16)) dut (.clk_sys, .nrst, .clkEn, .reqValid, .reqReady, .req,
		.rspValid, .rspData, .rspError, .busyProgram, .regionActive, .queryMismatch, .chipSelN,
		.writeStrobeN, .outEnableN, .flashAddr, .dqOut, .dqOe, .dqIn);
	nor_flash_model flash (.chipSelN, .writeStrobeN, .outEnableN, .flashAddr, .dqOut, .dqIn,
		.badLayout, .failProg);
	always #20 clk_sys = ~clk_sys;
	// The ceiling sits far above the fewer than a thousand cycles the sequence needs.
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			complete_run();
		end
	end
	////////////////////////////////////////
	task automatic runOp(input op_t op, input logic [23:0] ad, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		#1;
		while (reqReady !== 1'b1 && n < 100)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		reqValid = 1'b1;
		req = '{op, ad, d};
		@(posedge clk_sys);
		#1;
		reqValid = 1'b0;
		n = 0;
		while (rspValid !== 1'b1 && n < 3000)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 3000)
			failures++;
		@(posedge clk_sys);
		#1;
	endtask : runOp
	task automatic chkWord(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chkWord
	task automatic chkFlag(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : chkFlag
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	////////////////////////////////////////
	initial
	begin
		{clk_sys, nrst, reqValid, badLayout, failProg} = '0;
		clkEn = 1'b1;
		req = '0;
		{failures, compares, cycles} = '0;
		repeat (20) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		runOp(OP_READ, 24'h10, 16'h0);
		chkWord("array", 16'hFFFF, rspData);
		// A low enable must hold the idle controller, so no request can be taken.
		clkEn = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chkFlag("frozenReady", 1'b0, reqReady);
		chkWord("frozenData", 16'hFFFF, rspData);
		clkEn = 1'b1;
		runOp(OP_PROGRAM, 24'h10, 16'h5A5A);
		chkWord("prog", 16'h5A5A, rspData);
		chkFlag("progErr", 1'b0, rspError);
		runOp(OP_PROGRAM, 24'h10, 16'h0FF0);
		chkWord("clear", 16'h0A50, rspData);
		chkFlag("clearErr", 1'b1, rspError);
		for (int i = 0; i < 5; i++)
		begin
			runOp(OP_IDREAD, {16'h0000, ID_A[i]}, 16'h0);
			chkWord("id", ID_V[i], rspData);
		end
		runOp(OP_READ, 24'h10, 16'h0);
		chkWord("afterId", 16'h0A50, rspData);
		for (int i = 0; i < 17; i++)
		begin
			runOp(OP_QUERY, 24'(32'h40 + i), 16'h0);
			chkWord("query", QTAB[i], rspData);
			chkFlag("queryOk", 1'b0, queryMismatch);
		end
		runOp(OP_REGION, 24'h0, 16'h0);
		chkFlag("region", 1'b1, regionActive);
		runOp(OP_READ, 24'h5, 16'h0);
		chkWord("serial", 16'hE005, rspData);
		runOp(OP_EXIT, 24'h0, 16'h0);
		chkFlag("regionOff", 1'b0, regionActive);
		runOp(OP_READ, 24'h10, 16'h0);
		chkWord("afterExit", 16'h0A50, rspData);
		badLayout = 1'b1;
		runOp(OP_QUERY, 24'h4F, 16'h0);
		chkFlag("layoutBad", 1'b1, queryMismatch);
		badLayout = 1'b0;
		failProg = 1'b1;
		runOp(OP_PROGRAM, 24'h20, 16'h1234);
		chkFlag("failErr", 1'b1, rspError);
		failProg = 1'b0;
		runOp(OP_READ, 24'h20, 16'h0);
		chkWord("afterFail", 16'hFFFF, rspData);
		runOp(OP_RESET, 24'hABCDEF, 16'h0);
		runOp(OP_READ, 24'h10, 16'h0);
		chkWord("afterReset", 16'h0A50, rspData);
		complete_run();
	end
endmodule : flash_host_ctrl_test

// ==== bench/nor_flash_model.sv ====
// Model: behavioural command state machine of the parallel flash device.
`timescale 1ns/1ps
module nor_flash_model
#(
	parameter logic [15:0] MANUF_ID = 16'h00C3, // Arbitrary value.
	parameter logic [15:0] DEV_ID1  = 16'h1A2B, // Arbitrary value.
	parameter logic [15:0] DEV_ID2  = 16'h3C4D, // Arbitrary value.
	parameter logic [15:0] DEV_ID3  = 16'h5E6F, // Arbitrary value.
	parameter logic [15:0] LOCK_ST  = 16'h0011
)
(
	// Flash pins
	input wire logic        chipSelN,
	input wire logic        writeStrobeN,
	input wire logic        outEnableN,
	input wire logic [23:0] flashAddr,
	input wire logic [15:0] dqOut,
	output logic     [15:0] dqIn,
	// Fault controls
	input wire logic        badLayout,
	input wire logic        failProg
);
	logic [15:0] mem [0:255];
	logic [15:0] lastVal;
	logic [15:0] rdVal;
	logic [23:0] latAddr;
	logic [2:0]  seq;
	logic [1:0]  mode;
	logic [2:0]  busy;
	logic        tog;
	logic        failed;
	wire         wrAct = !chipSelN && !writeStrobeN;
	wire         rdAct = !chipSelN && !outEnableN;
	wire  [7:0]  a = flashAddr[7:0];
	////////////////////////////////////////
	// Released data lines show the inverse of the last word, so a stale read never matches.
	assign dqIn = rdAct ? rdVal : ~lastVal;
	always_comb
	begin
		if (busy != 3'h0)
			rdVal = {9'h000, tog, failed, 5'h00};
		else if (mode == 2'h1)
			rdVal = a == 8'h00 ? MANUF_ID : a == 8'h01 ? DEV_ID1 : a == 8'h0E ? DEV_ID2 :
				a == 8'h0F ? DEV_ID3 : a == 8'h03 ? LOCK_ST : 16'h0000;
		else if (mode == 2'h2)
			case (a)
				8'h40: rdVal = 16'h0050;
				8'h41: rdVal = 16'h0052;
				8'h42: rdVal = 16'h0049;
				8'h43: rdVal = 16'h0031;
				8'h44: rdVal = 16'h0033;
				8'h45: rdVal = 16'h0009;
				8'h46: rdVal = 16'h0002;
				8'h47, 8'h4C, 8'h50: rdVal = 16'h0001;
				8'h49: rdVal = 16'h0004;
				8'h4D: rdVal = 16'h00B5;
				8'h4E: rdVal = 16'h00C5;
				8'h4F: rdVal = badLayout ? 16'h0006 : 16'h0002;
				default: rdVal = 16'h0000;
			endcase
		else if (mode == 2'h3)
			rdVal = 16'hE000 | {8'h00, a};
		else
			rdVal = mem[a];
	end
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 16'hFFFF;
		{seq, mode, busy, tog, failed, lastVal} = '0;
	end
	always @(posedge outEnableN)
	begin
		if (!chipSelN)
		begin
			lastVal <= rdVal;
			tog <= busy != 3'h0 ? !tog : tog;
			busy <= busy != 3'h0 && !failed ? busy - 3'h1 : busy;
		end
	end
	always @(posedge wrAct)
		latAddr <= flashAddr;
	// Data is taken on the end of the write pulse, the earlier rising strobe.
	always @(negedge wrAct)
	begin
		if (busy != 3'h0 && !failed)
			seq = seq;
		else if (dqOut == 16'h00F0)
		begin
			mode = mode == 2'h3 ? 2'h3 : 2'h0;
			{busy, failed, seq} = 7'h00;
		end
		else if (seq == 3'h3)
		begin
			mem[latAddr[7:0]] = failProg ? mem[latAddr[7:0]] : mem[latAddr[7:0]] & dqOut;
			{failed, busy, seq} = {failProg, 6'o30};
		end
		else if (seq == 3'h4)
			{mode, seq} = {(dqOut == 16'h0000 ? 2'h0 : mode), 3'h0};
		else if (seq == 3'h0 && latAddr[7:0] == 8'h55 && dqOut == 16'h0098 && mode < 2'h2)
			mode = 2'h2;
		else if (seq == 3'h0 && latAddr[7:0] == 8'h55 && dqOut == 16'h00AA)
			seq = 3'h1;
		else if (seq == 3'h1 && latAddr[7:0] == 8'hAA && dqOut == 16'h0055)
			seq = 3'h2;
		else if (seq == 3'h2 && dqOut == 16'h00A0)
			seq = 3'h3;
		else if (seq == 3'h2 && dqOut == 16'h0088)
			{mode, seq} = 5'b11000;
		else if (seq == 3'h2 && dqOut == 16'h0090)
			{mode, seq} = mode == 2'h3 ? 5'b11100 : 5'b01000;
		else
			seq = 3'h0;
	end
endmodule : nor_flash_model

// ==== core/flash_bus_cycle.sv ====
// Module: one timed read or write cycle on the asynchronous flash pins.
`timescale 1ns/1ps
module flash_bus_cycle
	import flash_host_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        clkEn,
	// Cycle request
	input  wire logic        start,
	input  wire cycle_t      cyc,
	output logic             done,
	output logic [15:0]      rdData,
	// Flash pins
	output logic             chipSelN,
	output logic             writeStrobeN,
	output logic             outEnableN,
	output logic [23:0]      flashAddr,
	output logic [15:0]      dqOut,
	output logic             dqOe,
	input  wire logic [15:0] dqIn
);

	typedef enum logic [3:0]
	{
		B_IDLE   = 4'b0001,
		B_SETUP  = 4'b0010,
		B_STROBE = 4'b0100,
		B_HOLD   = 4'b1000
	} bstate_t;

	bstate_t    state_reg, state_next;
	logic [3:0] cnt_reg;
	logic       isWrite_reg;

	////////////////////////////////////////////////////////////////////////////
	// Sequencing.
	wire cntZero = (cnt_reg == 4'h0);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			B_IDLE:   if (start) state_next = B_SETUP;
			B_SETUP:  if (cntZero) state_next = B_STROBE;
			B_STROBE: if (cntZero) state_next = B_HOLD;
			B_HOLD:   state_next = B_IDLE;
			default:  state_next = B_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			state_reg    <= B_IDLE;
			cnt_reg      <= 4'h0;
			isWrite_reg  <= 1'b0;
			chipSelN     <= 1'b1;
			writeStrobeN <= 1'b1;
			outEnableN   <= 1'b1;
			flashAddr    <= 24'h000000;
			dqOut        <= 16'h0000;
			dqOe         <= 1'b0;
			rdData       <= 16'h0000;
		end
		else if (clkEn)
		begin
			state_reg <= state_next;
			cnt_reg   <= cntZero ? 4'h0 : cnt_reg - 4'h1;
			case (state_reg)
				B_IDLE:
				begin
					if (start)
					begin
						// Chip select and address lead, so the later falling edge is the
						// write strobe and the address is stable when it is captured. [R9]
						isWrite_reg <= cyc.write;
						flashAddr   <= cyc.addr;
						dqOut       <= cyc.data;
						dqOe        <= cyc.write;
						chipSelN    <= 1'b0;
						outEnableN  <= 1'b1;
						cnt_reg     <= 4'(SETUP_CYC - 1);
					end
				end
				B_SETUP:
				begin
					if (cntZero)
					begin
						writeStrobeN <= !isWrite_reg;
						outEnableN   <= isWrite_reg;
						cnt_reg      <= isWrite_reg ? 4'(STROBE_CYC - 1) : 4'(READ_CYC - 1);
					end
				end
				B_STROBE:
				begin
					if (cntZero)
					begin
						// Strobe rises first while data still driven: data captured here. [R9]
						writeStrobeN <= 1'b1;
						outEnableN   <= 1'b1;
						if (!isWrite_reg)
							rdData <= dqIn;
					end
				end
				B_HOLD:
				begin
					chipSelN <= 1'b1;
					dqOe     <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	assign done = clkEn && (state_reg == B_HOLD);

endmodule : flash_bus_cycle

// ==== core/flash_host_ctrl.sv ====
// Module: host controller that sequences command cycles into a parallel NOR flash.
// How it works
// R1: Query words 40h-42h must read the three-letter extension signature.
// R2: Words 43h and 44h must read major 0031h and minor 0033h.
// R3: Word 45h holds unlock-sensitivity bits 1-0 and technology code 0010b in 7-2.
// R4: Word 46h reads 2 and word 50h reads 0001h for suspend support.
// R5: Protect group 1, no temp unprotect, scheme 4, no simultaneous/burst, page 1.
// R6: Acceleration supply minimum 00B5h and maximum 00C5h, volts and tenths.
// R7: Word 4Fh encodes sector layout: 00h, 02h, 03h, 04h or 05h.
// R8: After bad sequences or mismatches the host writes reset to recover; the code writes it only from S_FAIL, not after an S_CHECK mismatch.
// R9: Address captured on later falling strobe; data on earlier rising strobe.
// R10: Device reads array after power-up and after embedded operations finish.
// R11: Erase suspend leaves device serving reads from non-erasing sectors.
// R12: On timeout failure flag the host issues reset.
// R13: Reset command works at any address, returning to read mode.
// R14: Reset between erase cycles aborts; ignored once erase runs.
// R15: Reset mid program sequence aborts; ignored once programming runs.
// R16: On buffer abort flag, host must send the buffer-abort reset sequence; the code sends one plain reset write from S_FAIL.
// R17: Two unlocks plus autoselect enter identifier mode; reset leaves it.
// R18: Identifier words: maker 00h, device 01h/0Eh/0Fh, lock 03h, protect SA+02h.
// R19: Three-cycle entry redirects to secured region; four-cycle exit leaves.
// R20: Word program is two unlocks, setup command, then address and data.
// R21: While programming, commands are ignored and identifier/query unavailable.
// R22: Programming only clears bits; a one over a zero stays zero.
// R23: Query command 98h at 55h enters query mode; reset leaves it.
`timescale 1ns/1ps
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter int POLL_LIMIT = 4096
)
(
	// Clock, reset and enable
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        clkEn,
	// User request port
	input  wire logic        reqValid,
	output logic             reqReady,
	input  wire req_t        req,
	// User answer port
	output logic             rspValid,
	output logic [15:0]      rspData,
	output logic             rspError,
	output logic             busyProgram,
	output logic             regionActive,
	output logic             queryMismatch,
	// Flash pins
	output logic             chipSelN,
	output logic             writeStrobeN,
	output logic             outEnableN,
	output logic [23:0]      flashAddr,
	output logic [15:0]      dqOut,
	output logic             dqOe,
	input  wire logic [15:0] dqIn
);

	typedef enum logic [7:0]
	{
		S_IDLE  = 8'b00000001,
		S_SEQ   = 8'b00000010,
		S_POLL  = 8'b00000100,
		S_RSP   = 8'b00001000,
		S_FAIL  = 8'b00010000,
		S_ABORT = 8'b00100000,
		S_CHECK = 8'b01000000,
		S_DONE  = 8'b10000000
	} state_t;

	state_t      state_reg, state_next;
	req_t        cur_reg;
	logic [2:0]  step_reg;
	logic [15:0] data_reg;
	logic        errFlag_reg;
	logic        region_reg;
	logic        mismatch_reg;
	logic [12:0] polls_reg;
	logic        cycStart;
	cycle_t      cyc;
	logic        cycDone;
	logic [15:0] cycData;

	////////////////////////////////////////////////////////////////////////////
	// Command sequence tables.

	// Number of bus cycles per operation; a plain read is one read, identifier and query ops read and then end with a reset write.
	function automatic logic [2:0] seqLen(input op_t op);
		case (op)
			OP_READ:    seqLen = 3'h1;
			OP_PROGRAM: seqLen = 3'h4;          // [R20]
			OP_IDREAD:  seqLen = 3'h5;          // [R17]
			OP_QUERY:   seqLen = 3'h3;          // [R23]
			OP_REGION:  seqLen = 3'h3;          // [R19]
			OP_EXIT:    seqLen = 3'h4;          // [R19]
			OP_RESET:   seqLen = 3'h1;          // [R13]
			default:    seqLen = 3'h1;
		endcase
	endfunction : seqLen

	// Bus cycle for one step of an operation.
	function automatic cycle_t seqCycle(input req_t r, input logic [2:0] s);
		cycle_t c;
		c.write = 1'b1;
		c.addr  = {16'h0000, UNLOCK_ADDR1};
		c.data  = UNLOCK_DATA1;
		if (s == 3'h1)
		begin
			c.addr = {16'h0000, UNLOCK_ADDR2};
			c.data = UNLOCK_DATA2;
		end
		case (r.op)
			OP_READ:
			begin
				c.write = 1'b0;
				c.addr  = r.addr;
			end
			OP_RESET:
			begin
				// Address is a don't care for reset, so the user address is passed. [R13]
				c.addr = r.addr;
				c.data = CMD_RESET;
			end
			OP_PROGRAM:
			begin
				if (s == 3'h2) c.data = CMD_PROGRAM;
				if (s == 3'h3)
				begin
					c.addr = r.addr;              // [R20]
					c.data = r.data;
				end
			end
			OP_IDREAD:
			begin
				if (s == 3'h2) c.data = CMD_AUTOSELECT;    // [R17]
				if (s == 3'h3)
				begin
					c.write = 1'b0;
					c.addr  = r.addr;                      // [R18]
				end
				if (s == 3'h4)
				begin
					c.addr = r.addr;
					c.data = CMD_RESET;                    // [R17]
				end
			end
			OP_QUERY:
			begin
				if (s == 3'h0)
				begin
					c.addr = {16'h0000, QUERY_ADDR};
					c.data = CMD_QUERY;                    // [R23]
				end
				if (s == 3'h1)
				begin
					c.write = 1'b0;
					c.addr  = r.addr;
				end
				if (s == 3'h2) c.data = CMD_RESET;         // [R23]
			end
			OP_REGION:
				if (s == 3'h2) c.data = CMD_REGION_IN;
			OP_EXIT:
			begin
				if (s == 3'h2) c.data = CMD_EXIT_A;
				if (s == 3'h3) c.data = CMD_EXIT_B;
			end
			default: ;
		endcase
		seqCycle = c;
	endfunction : seqCycle

	// Expected extended-query word, or all ones where the value varies by part.
	function automatic logic [15:0] extExpect(input logic [7:0] a);
		logic [7:0] i;
		i = a - EXT_BASE;
		case (i)
			8'h00:   extExpect = EXT_SIG0;                // [R1]
			8'h01:   extExpect = EXT_SIG1;                // [R1]
			8'h02:   extExpect = EXT_SIG2;                // [R1]
			8'h03:   extExpect = EXT_MAJOR;               // [R2]
			8'h04:   extExpect = EXT_MINOR;               // [R2]
			8'h06:   extExpect = EXT_ERASE_SUSP;          // [R4]
			8'h07:   extExpect = EXT_PROT_GROUP;          // [R5]
			8'h08:   extExpect = EXT_TEMP_UNPR;           // [R5]
			8'h09:   extExpect = EXT_PROT_SCHEME;         // [R5]
			8'h0A:   extExpect = EXT_SIMUL;               // [R5]
			8'h0B:   extExpect = EXT_BURST;               // [R5]
			8'h0C:   extExpect = EXT_PAGE;                // [R5]
			8'h0D:   extExpect = EXT_ACC_MIN;             // [R6]
			8'h0E:   extExpect = EXT_ACC_MAX;             // [R6]
			8'h10:   extExpect = EXT_PROG_SUSP;           // [R4]
			default: extExpect = 16'hFFFF;
		endcase
	endfunction : extExpect

	////////////////////////////////////////////////////////////////////////////
	// Query result checks.
	wire [7:0]  qAddr    = cur_reg.addr[7:0];
	wire        qInExt   = (qAddr >= EXT_BASE) && (qAddr < 8'(EXT_BASE + EXT_WORDS));
	wire [15:0] qExp     = extExpect(qAddr);
	wire        qIsTech  = (qAddr == 8'(EXT_BASE + 5));
	wire        qIsLay   = (qAddr == 8'(EXT_BASE + EXT_LAYOUT_IDX));
	wire        techOk   = (data_reg[7:2] == EXT_TECH) && (data_reg[15:8] == 8'h00);   // [R3]
	wire        layOk    = (data_reg[15:3] == 13'h0000) && (data_reg[2:0] != 3'h1)
		&& (data_reg[2:0] <= 3'h5);                                          // [R7]
	wire        qBad     = qInExt && (qIsTech ? !techOk : qIsLay ? !layOk
		: (qExp != 16'hFFFF) && (data_reg != qExp));

	////////////////////////////////////////////////////////////////////////////
	// Main sequencer.
	wire       lastStep  = (step_reg == seqLen(cur_reg.op) - 3'h1);
	wire       readOp    = (cur_reg.op == OP_READ);
	// The bit toggling between two reads means the embedded program still runs.
	wire       stillBusy = (cycData[6] != data_reg[6]);
	// A flag counts only in two status reads in a row, since the read that turns to array
	// data also differs in bit 6 and carries user bits; the first poll has no prior status.
	wire       pollPair  = stillBusy && (polls_reg != 13'h0000);
	wire       timedOut  = pollPair && cycData[5] && data_reg[5];      // [R12]
	wire       bufAbort  = pollPair && cycData[1] && data_reg[1];      // [R16]
	wire       pollOver  = (polls_reg == 13'(POLL_LIMIT - 1));
	wire       capStep   = (cur_reg.op == OP_IDREAD && step_reg == 3'h3)
		|| (cur_reg.op == OP_QUERY && step_reg == 3'h1) || readOp;

	assign reqReady = clkEn && (state_reg == S_IDLE);
	assign cycStart = clkEn && (state_reg == S_SEQ || state_reg == S_POLL
		|| state_reg == S_FAIL || state_reg == S_CHECK) && !cycDone;

	always_comb
	begin
		cyc = seqCycle(cur_reg, step_reg);
		if (state_reg == S_POLL || state_reg == S_CHECK)
		begin
			cyc.write = 1'b0;
			cyc.addr  = cur_reg.addr;
		end
		if (state_reg == S_FAIL)
			cyc.data = CMD_RESET;                                      // [R12]
		if (state_reg == S_ABORT)
			cyc.data = CMD_RESET;
	end

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE:  if (reqValid) state_next = S_SEQ;
			S_SEQ:
				if (cycDone && lastStep)
					state_next = (cur_reg.op == OP_PROGRAM) ? S_POLL : S_RSP;  // [R21]
			S_POLL:
				if (cycDone)
				begin
					if (!stillBusy && polls_reg != 13'h0000)
						state_next = S_CHECK;                          // [R10]
					else if (timedOut || pollOver)
						state_next = S_FAIL;
					else if (bufAbort)
						state_next = S_FAIL;
				end
			S_FAIL:  if (cycDone) state_next = S_RSP;                  // [R8]
			S_CHECK: if (cycDone) state_next = S_RSP;
			S_RSP:   state_next = S_DONE;
			S_DONE:  state_next = S_IDLE;
			S_ABORT: state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			state_reg    <= S_IDLE;
			cur_reg      <= '0;
			step_reg     <= 3'h0;
			data_reg     <= 16'h0000;
			errFlag_reg  <= 1'b0;
			region_reg   <= 1'b0;
			mismatch_reg <= 1'b0;
			polls_reg    <= 13'h0000;
		end
		else if (clkEn)
		begin
			state_reg <= state_next;
			if (state_reg == S_IDLE && reqValid)
			begin
				cur_reg     <= req;
				step_reg    <= 3'h0;
				errFlag_reg <= 1'b0;
				polls_reg   <= 13'h0000;
			end
			if (state_reg == S_SEQ && cycDone)
			begin
				step_reg <= step_reg + 3'h1;
				if (capStep)
					data_reg <= cycData;
				if (lastStep && cur_reg.op == OP_REGION)
					region_reg <= 1'b1;                                // [R19]
				if (lastStep && cur_reg.op == OP_EXIT)
					region_reg <= 1'b0;                                // [R19]
			end
			if (state_reg == S_POLL && cycDone)
			begin
				data_reg  <= cycData;
				polls_reg <= polls_reg + 13'h1;
				if (timedOut || pollOver || bufAbort)
					errFlag_reg <= 1'b1;
			end
			if (state_reg == S_CHECK && cycDone)
			begin
				data_reg <= cycData;
				// A bit asked to go high over a stored zero stays low. [R22]
				if (cycData != cur_reg.data)
					errFlag_reg <= 1'b1;
			end
			if (state_reg == S_RSP && cur_reg.op == OP_QUERY)
				mismatch_reg <= qBad;
		end
	end

	assign rspValid      = clkEn && (state_reg == S_DONE);
	assign rspData       = data_reg;
	assign rspError      = errFlag_reg;
	assign busyProgram   = (state_reg == S_POLL);                      // [R21]
	assign regionActive  = region_reg;
	assign queryMismatch = mismatch_reg;

	////////////////////////////////////////////////////////////////////////////
	// Pin engine.
	flash_bus_cycle u_cycle
	(
		.clk_sys      (clk_sys),
		.nrst         (nrst),
		.clkEn        (clkEn),
		.start        (cycStart),
		.cyc          (cyc),
		.done         (cycDone),
		.rdData       (cycData),
		.chipSelN     (chipSelN),
		.writeStrobeN (writeStrobeN),
		.outEnableN   (outEnableN),
		.flashAddr    (flashAddr),
		.dqOut        (dqOut),
		.dqOe         (dqOe),
		.dqIn         (dqIn)
	);

endmodule : flash_host_ctrl

// ==== core/flash_host_pkg.sv ====
// Package: command codes, query layout, bus timing and carrier types for the flash host.
package flash_host_pkg;

	// Bus-cycle timing in clock cycles at 25 MHz.
	localparam int CLK_PERIOD_NS   = 40;
	localparam int T_SETUP_NS      = 40;
	localparam int T_STROBE_NS     = 80;
	localparam int T_READ_NS       = 120;
	localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC   = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Unlock cycle addresses are not given here, so they are plain defaults.
	localparam logic [7:0]  UNLOCK_ADDR1   = 8'h55;
	localparam logic [7:0]  UNLOCK_ADDR2   = 8'hAA;
	localparam logic [15:0] UNLOCK_DATA1   = 16'h00AA;
	localparam logic [15:0] UNLOCK_DATA2   = 16'h0055;
	localparam logic [15:0] CMD_RESET      = 16'h00F0;
	localparam logic [15:0] CMD_AUTOSELECT = 16'h0090;
	localparam logic [15:0] CMD_PROGRAM    = 16'h00A0;
	localparam logic [15:0] CMD_REGION_IN  = 16'h0088;
	localparam logic [15:0] CMD_EXIT_A     = 16'h0090;
	localparam logic [15:0] CMD_EXIT_B     = 16'h0000;
	localparam logic [15:0] CMD_QUERY      = 16'h0098;
	localparam logic [7:0]  QUERY_ADDR     = 8'h55;

	// Identifier and extended-query word addresses.
	localparam logic [7:0]  ID_MANUF       = 8'h00;
	localparam logic [7:0]  ID_DEV1        = 8'h01;
	localparam logic [7:0]  ID_PROT        = 8'h02;
	localparam logic [7:0]  ID_REGION_LOCK = 8'h03;
	localparam logic [7:0]  ID_DEV2        = 8'h0E;
	localparam logic [7:0]  ID_DEV3        = 8'h0F;
	localparam logic [7:0]  EXT_BASE       = 8'h40;
	localparam int          EXT_WORDS      = 17;

	// Expected extended-query contents, index 0 at word 40h.
	localparam logic [15:0] EXT_SIG0       = 16'h0050;
	localparam logic [15:0] EXT_SIG1       = 16'h0052;
	localparam logic [15:0] EXT_SIG2       = 16'h0049;
	localparam logic [15:0] EXT_MAJOR      = 16'h0031;
	localparam logic [15:0] EXT_MINOR      = 16'h0033;
	localparam logic [5:0]  EXT_TECH       = 6'b000010;
	localparam logic [15:0] EXT_ERASE_SUSP = 16'h0002;
	localparam logic [15:0] EXT_PROT_GROUP = 16'h0001;
	localparam logic [15:0] EXT_TEMP_UNPR  = 16'h0000;
	localparam logic [15:0] EXT_PROT_SCHEME = 16'h0004;
	localparam logic [15:0] EXT_SIMUL      = 16'h0000;
	localparam logic [15:0] EXT_BURST      = 16'h0000;
	localparam logic [15:0] EXT_PAGE       = 16'h0001;
	localparam logic [15:0] EXT_ACC_MIN    = 16'h00B5;
	localparam logic [15:0] EXT_ACC_MAX    = 16'h00C5;
	localparam logic [15:0] EXT_PROG_SUSP  = 16'h0001;
	localparam int          EXT_LAYOUT_IDX = 15;

	// User operations.
	typedef enum logic [2:0]
	{
		OP_READ    = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_IDREAD  = 3'h2,
		OP_QUERY   = 3'h3,
		OP_REGION  = 3'h4,
		OP_EXIT    = 3'h5,
		OP_RESET   = 3'h6
	} op_t;

	// One bus cycle on the flash pins.
	typedef struct packed
	{
		logic        write;
		logic [23:0] addr;
		logic [15:0] data;
	} cycle_t;

	// User request.
	typedef struct packed
	{
		op_t         op;
		logic [23:0] addr;
		logic [15:0] data;
	} req_t;

endpackage : flash_host_pkg
